// File: design/lbp_pkg.sv
// package: constants and types of the logic block slice pair
package lbp_pkg;
    localparam int N_SLICE   = 2;
    localparam int N_CELL    = 4;
    localparam int N_DRV     = 2;
    localparam int LUT_IN_W  = 4;
    localparam int LUT_DEPTH = 16;
    localparam int ADDR_W    = 3;
    localparam int DATA_W    = 16;

    // register map (word addresses on the plain register port)
    localparam logic [ADDR_W-1:0] ADDR_LUT0 = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CFG0 = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_CFG1 = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_MISC = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h7;

    // slice configuration fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_COMB_LSB = 4;
    localparam int CFG_LATCH    = 6;
    localparam int CFG_BYP_LSB  = 7;
    localparam int CFG_INIT_LSB = 9;
    localparam int CFG_ASYNC    = 11;
    localparam int CFG_INV_CLK  = 12;
    localparam int CFG_INV_CE   = 13;
    localparam int CFG_INV_INIT = 14;
    localparam int CFG_INV_OPP  = 15;
    localparam int STAT_BUS     = 4;

    localparam logic [DATA_W-1:0]    CFG_RST  = 16'h0000;
    localparam logic [LUT_DEPTH-1:0] LUT_RST  = 16'h0000;
    localparam logic [N_SLICE-1:0]   MISC_RST = 2'h0;

    typedef enum logic [1:0] {
        LUT_LOGIC = 2'h0,
        LUT_RAM   = 2'h1,
        LUT_SHIFT = 2'h2
    } lbp_lut_mode_e;

    typedef enum logic [1:0] {
        COMB_NONE = 2'h0,
        COMB_16X2 = 2'h1,
        COMB_32X1 = 2'h2,
        COMB_DUAL = 2'h3
    } lbp_comb_e;
endpackage

// File: design/lbp_block.sv
// logic block with two slices of two logic cells each
`timescale 1ns/1ps

// Summary of operation
// [RULE_01] cell: table, carry, storage element
// [RULE_02] four cells in two slices
// [RULE_03] table is logic or 16x1 RAM
// [RULE_04] slice RAM: 16x2, 32x1, dual port
// [RULE_05] table works as 16-bit shift register
// [RULE_06] storage element: flip-flop or latch
// [RULE_07] data input: table or bypass input
// [RULE_08] init force loads configured value
// [RULE_09] opposite force loads its complement
// [RULE_10] forces synchronous, optionally asynchronous
// [RULE_11] clock, enable, forces invertible, slice-shared
// [RULE_12] five-input mux picks slice table output
// [RULE_13] six-input mux picks five-input output
// [RULE_14] four direct feedthrough paths
// [RULE_15] one carry chain per slice
// [RULE_16] XOR sum and AND partial product
// [RULE_17] carry path cascades wide logic
// [RULE_18] two bus drivers, own data, enable
// [RULE_19] driver drives only while enable low
// [RULE_20] undriven bus net reads high
// [RULE_21] conflicting drivers resolve to low
// [RULE_22] flip-flop holds while enable inactive
module lbp_block (
    input  wire logic                                      REF_CLK,
    input  wire logic                                      RESETN,
    input  wire logic [lbp_pkg::ADDR_W-1:0]                REG_ADDR,
    input  wire logic [lbp_pkg::DATA_W-1:0]                REG_WDATA,
    input  wire logic                                      REG_WR,
    input  wire logic                                      REG_RD,
    output logic      [lbp_pkg::DATA_W-1:0]                REG_RDATA,
    input  wire logic [lbp_pkg::N_CELL*lbp_pkg::LUT_IN_W-1:0] LUT_IN,
    input  wire logic [lbp_pkg::N_CELL-1:0]                BYPASS_IN,
    input  wire logic [lbp_pkg::N_SLICE-1:0]               SLICE_CLK,
    input  wire logic [lbp_pkg::N_SLICE-1:0]               SLICE_CE,
    input  wire logic [lbp_pkg::N_SLICE-1:0]               INIT_FORCE,
    input  wire logic [lbp_pkg::N_SLICE-1:0]               OPPOSITE_FORCE,
    input  wire logic [lbp_pkg::N_SLICE-1:0]               RAM_WE,
    input  wire logic [lbp_pkg::N_CELL-1:0]                RAM_WD,
    input  wire logic [lbp_pkg::N_SLICE-1:0]               CARRY_IN,
    input  wire logic [lbp_pkg::N_SLICE-1:0]               FIVE_SEL,
    input  wire logic                                      SIX_SEL,
    input  wire logic [lbp_pkg::N_CELL-1:0]                FEED_IN,
    input  wire logic [lbp_pkg::N_DRV-1:0]                 BUS_DATA,
    input  wire logic [lbp_pkg::N_DRV-1:0]                 BUS_EN_N,
    input  wire logic                                      BUS_IN,
    output logic      [lbp_pkg::N_CELL-1:0]                LUT_OUT,
    output logic      [lbp_pkg::N_CELL-1:0]                Q_OUT,
    output logic      [lbp_pkg::N_CELL-1:0]                SUM_OUT,
    output logic      [lbp_pkg::N_SLICE-1:0]               CARRY_OUT,
    output logic      [lbp_pkg::N_SLICE-1:0]               FIVE_OUT,
    output logic                                           SIX_OUT,
    output logic      [lbp_pkg::N_CELL-1:0]                FEED_OUT,
    output logic                                           BUS_OUT
);
    import lbp_pkg::*;

    logic [LUT_DEPTH-1:0] table_ff [N_CELL];
    logic [DATA_W-1:0]    cfg_ff   [N_SLICE];
    logic [N_SLICE-1:0]   misc_ff;
    logic [DATA_W-1:0]    rdata_ff;
    logic [DATA_W-1:0]    nxt_rdata;
    logic [N_SLICE-1:0]   clk_prev_ff;
    logic [N_CELL-1:0]    q_ff;
    logic [N_CELL-1:0]    lut_out_ff;
    logic [N_CELL-1:0]    sum_ff;
    logic [N_SLICE-1:0]   cout_ff;
    logic [N_SLICE-1:0]   five_ff;
    logic                 six_ff;
    logic [N_CELL-1:0]    feed_ff;
    logic                 bus_ff;

    logic [N_SLICE-1:0]   clk_lvl;
    logic [N_SLICE-1:0]   clk_edge;
    logic [N_SLICE-1:0]   ce_act;
    logic [N_SLICE-1:0]   init_act;
    logic [N_SLICE-1:0]   opp_act;
    logic [N_SLICE-1:0]   async_en;
    logic [N_SLICE-1:0]   latch_en;
    logic [N_SLICE-1:0]   upd;
    logic [N_SLICE-1:0]   five;
    lbp_comb_e            comb     [N_SLICE];

    logic [LUT_IN_W-1:0]  ra       [N_CELL];
    logic [LUT_IN_W-1:0]  wa       [N_CELL];
    logic [N_CELL-1:0]    lut_val;
    logic [N_CELL-1:0]    wd;
    logic [N_CELL-1:0]    we;
    logic [N_CELL-1:0]    sh_en;
    logic [N_CELL-1:0]    d;
    logic [N_CELL-1:0]    initv;
    logic [N_CELL-1:0]    ci;
    logic [N_CELL-1:0]    co;
    logic [N_CELL-1:0]    di;
    logic [N_DRV-1:0]     drv;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    // configuration registers
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_ff[0] <= CFG_RST;
            cfg_ff[1] <= CFG_RST;
            misc_ff   <= MISC_RST;
        end else if (REG_WR) begin
            if (REG_ADDR == ADDR_CFG0) begin
                cfg_ff[0] <= REG_WDATA;
            end
            if (REG_ADDR == ADDR_CFG1) begin
                cfg_ff[1] <= REG_WDATA;
            end
            if (REG_ADDR == ADDR_MISC) begin
                misc_ff <= REG_WDATA[N_SLICE-1:0];
            end
        end
    end

    always_comb begin
        nxt_rdata = '0;
        case (REG_ADDR)
            ADDR_CFG0: nxt_rdata = cfg_ff[0];
            ADDR_CFG1: nxt_rdata = cfg_ff[1];
            ADDR_MISC: nxt_rdata[N_SLICE-1:0] = misc_ff;
            ADDR_STAT: begin
                nxt_rdata[N_CELL-1:0] = q_ff;
                nxt_rdata[STAT_BUS]   = bus_ff;
            end
            default:   nxt_rdata = table_ff[REG_ADDR[1:0]];
        endcase
    end

    // read data stands for the one cycle after the strobe
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_ff <= '0;
        end else if (REG_RD) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= '0;
        end
    end

    // slice controls, shared by both cells of the slice
    for (genvar s = 0; s < N_SLICE; s++) begin : g_slice
        assign clk_lvl[s]  = SLICE_CLK[s] ^ cfg_ff[s][CFG_INV_CLK];          // RULE_11
        assign ce_act[s]   = SLICE_CE[s] ^ cfg_ff[s][CFG_INV_CE];            // RULE_11
        assign init_act[s] = INIT_FORCE[s] ^ cfg_ff[s][CFG_INV_INIT];        // RULE_11
        assign opp_act[s]  = OPPOSITE_FORCE[s] ^ cfg_ff[s][CFG_INV_OPP];     // RULE_11
        assign async_en[s] = cfg_ff[s][CFG_ASYNC];
        assign latch_en[s] = cfg_ff[s][CFG_LATCH];
        assign comb[s]     = lbp_comb_e'(cfg_ff[s][CFG_COMB_LSB +: 2]);
        assign clk_edge[s] = clk_lvl[s] & ~clk_prev_ff[s];
        assign upd[s]      = latch_en[s] ? clk_lvl[s] : clk_edge[s];         // RULE_06
        assign five[s]     = FIVE_SEL[s] ? lut_val[2*s+1] : lut_val[2*s];    // RULE_12
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            clk_prev_ff <= '0;
        end else begin
            clk_prev_ff <= clk_lvl;
        end
    end

    // four logic cells, two per slice
    for (genvar c = 0; c < N_CELL; c++) begin : g_cell                      // RULE_02
        localparam int S = c / 2;
        localparam int K = c % 2;
        lbp_lut_mode_e mode;
        logic          is_ram;
        logic          shr;

        assign mode   = lbp_lut_mode_e'(cfg_ff[S][CFG_MODE_LSB+2*K +: 2]);
        assign is_ram = (mode == LUT_RAM) || (comb[S] != COMB_NONE);         // RULE_03
        assign shr    = (K == 1) && (comb[S] == COMB_DUAL || comb[S] == COMB_32X1);
        // 16x2 and dual-port RAMs write both tables, 32x1 the FIVE_SEL table, at the first table's inputs; 16x2 and 32x1 also read there
        assign wa[c]  = (K == 1 && comb[S] == COMB_NONE) ?                   // RULE_04
                        LUT_IN[LUT_IN_W*c +: LUT_IN_W] : LUT_IN[LUT_IN_W*2*S +: LUT_IN_W];
        assign ra[c]  = (K == 1 && (comb[S] == COMB_16X2 || comb[S] == COMB_32X1)) ?
                        LUT_IN[LUT_IN_W*2*S +: LUT_IN_W] : LUT_IN[LUT_IN_W*c +: LUT_IN_W];
        assign wd[c]  = shr ? RAM_WD[2*S] : RAM_WD[c];                        // RULE_04
        assign we[c]  = RAM_WE[S] && clk_edge[S] && is_ram &&
                        (comb[S] != COMB_32X1 || FIVE_SEL[S] == 1'(K));      // RULE_04
        assign sh_en[c] = RAM_WE[S] && clk_edge[S] && !is_ram && mode == LUT_SHIFT;
        assign lut_val[c] = table_ff[c][ra[c]];                              // RULE_01
        assign d[c]     = cfg_ff[S][CFG_BYP_LSB+K] ? BYPASS_IN[c] : lut_val[c]; // RULE_07
        assign initv[c] = cfg_ff[S][CFG_INIT_LSB+K];

        // carry: propagate on table output, else take the AND term or bypass
        assign di[c] = misc_ff[S] ? BYPASS_IN[c] :
                       (LUT_IN[LUT_IN_W*c] & LUT_IN[LUT_IN_W*c+1]);          // RULE_16
        assign co[c] = lut_val[c] ? ci[c] : di[c];                           // RULE_15 RULE_17
        if (K == 0) begin : g_ci0
            assign ci[c] = CARRY_IN[S];
        end else begin : g_ci1
            assign ci[c] = co[c-1];                                          // RULE_15
        end

        // table storage: software load, shift, or synchronous RAM write
        always_ff @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) begin
                table_ff[c] <= LUT_RST;
            end else if (REG_WR && REG_ADDR == ADDR_LUT0 + 3'(c)) begin
                table_ff[c] <= REG_WDATA;
            end else if (sh_en[c]) begin
                table_ff[c] <= {table_ff[c][LUT_DEPTH-2:0], wd[c]};         // RULE_05
            end else if (we[c]) begin
                table_ff[c][wa[c]] <= wd[c];                                 // RULE_03
            end
        end

        // storage element
        always_ff @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) begin
                q_ff[c] <= 1'b0;
            end else if (async_en[S] && init_act[S]) begin
                q_ff[c] <= initv[c];                                         // RULE_08 RULE_10
            end else if (async_en[S] && opp_act[S]) begin
                q_ff[c] <= ~initv[c];                                        // RULE_09 RULE_10
            end else if (upd[S]) begin
                if (init_act[S]) begin
                    q_ff[c] <= initv[c];                                     // RULE_08
                end else if (opp_act[S]) begin
                    q_ff[c] <= ~initv[c];                                    // RULE_09
                end else if (ce_act[S]) begin
                    q_ff[c] <= d[c];                                         // RULE_06 RULE_22
                end
            end
        end

        cell_hold_a: assert property (                                       // RULE_22
            !latch_en[S] && clk_edge[S] && !ce_act[S] && !init_act[S] && !opp_act[S]
            |=> q_ff[c] == $past(q_ff[c]))
            else $error("flip-flop changed with enable inactive");

        latch_pass_a: assert property (                                      // RULE_06
            latch_en[S] && clk_lvl[S] && ce_act[S] && !init_act[S] && !opp_act[S]
            |=> q_ff[c] == $past(d[c]))
            else $error("open latch did not pass data");

        init_force_a: assert property (                                      // RULE_08
            async_en[S] && init_act[S] |=> q_ff[c] == $past(initv[c]))
            else $error("init force did not load initial value");

        opp_force_a: assert property (                                       // RULE_09
            async_en[S] && !init_act[S] && opp_act[S] |=> q_ff[c] != $past(initv[c]))
            else $error("opposite force did not load complement");

        sync_force_a: assert property (                                      // RULE_10
            !async_en[S] && init_act[S] && !upd[S] |=> $stable(q_ff[c]))
            else $error("synchronous force acted without clock");

        ram_write_a: assert property (                                       // RULE_03
            we[c] && !sh_en[c] && !REG_WR
            |=> table_ff[c][$past(wa[c])] == $past(wd[c]))
            else $error("table RAM write lost");

        shift_step_a: assert property (                                      // RULE_05
            sh_en[c] && !REG_WR
            |=> table_ff[c][0] == $past(wd[c]) && table_ff[c][1] == $past(table_ff[c][0]))
            else $error("shift register did not advance");
    end

    // bus drivers: enable active low, wired so that any low wins
    for (genvar i = 0; i < N_DRV; i++) begin : g_drv                         // RULE_18
        assign drv[i] = BUS_EN_N[i] ? 1'b1 : BUS_DATA[i];                    // RULE_19 RULE_20
    end

    // registered block outputs
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            lut_out_ff <= '0;
            sum_ff     <= '0;
            cout_ff    <= '0;
            five_ff    <= '0;
            six_ff     <= 1'b0;
            feed_ff    <= '0;
            bus_ff     <= 1'b1;
        end else begin
            lut_out_ff <= lut_val;                                           // RULE_01
            sum_ff     <= lut_val ^ ci;                                      // RULE_16
            cout_ff    <= {co[3], co[1]};                                    // RULE_15
            five_ff    <= five;                                              // RULE_12
            six_ff     <= SIX_SEL ? five[1] : five[0];                       // RULE_13
            feed_ff    <= FEED_IN;                                           // RULE_14
            bus_ff     <= &drv & BUS_IN;                                     // RULE_20 RULE_21
        end
    end

    assign REG_RDATA = rdata_ff;
    assign LUT_OUT   = lut_out_ff;
    assign Q_OUT     = q_ff;
    assign SUM_OUT   = sum_ff;
    assign CARRY_OUT = cout_ff;
    assign FIVE_OUT  = five_ff;
    assign SIX_OUT   = six_ff;
    assign FEED_OUT  = feed_ff;
    assign BUS_OUT   = bus_ff;

    five_mux_a: assert property (                                            // RULE_12
        1'b1 |=> FIVE_OUT[0] == ($past(FIVE_SEL[0]) ? LUT_OUT[1] : LUT_OUT[0]))
        else $error("five-input mux picked wrong table");

    six_mux_a: assert property (                                             // RULE_13
        1'b1 |=> SIX_OUT == ($past(SIX_SEL) ? FIVE_OUT[1] : FIVE_OUT[0]))
        else $error("six-input mux picked wrong input");

    bus_idle_a: assert property (                                            // RULE_20
        BUS_EN_N == 2'h3 && BUS_IN |=> BUS_OUT)
        else $error("undriven bus not high");

    bus_low_a: assert property (                                             // RULE_21
        (!BUS_EN_N[0] && !BUS_DATA[0]) || (!BUS_EN_N[1] && !BUS_DATA[1]) |=> !BUS_OUT)
        else $error("driven low did not win");

    bus_drive_a: assert property (                                           // RULE_19
        BUS_EN_N == 2'h2 && BUS_IN |=> BUS_OUT == $past(BUS_DATA[0]))
        else $error("enabled driver not on bus");

    rd_once_a: assert property (
        !REG_RD |=> REG_RDATA == 16'h0000)
        else $error("read data outside its cycle");

    feed_path_a: assert property (                                           // RULE_14
        1'b1 |=> FEED_OUT == $past(FEED_IN))
        else $error("feedthrough path lost data");

    carry_pass_a: assert property (                                          // RULE_15
        lut_val[1:0] == 2'h3 |=> CARRY_OUT[0] == $past(CARRY_IN[0]))
        else $error("carry did not propagate through slice");

    ram_pair_a: assert property (                                            // RULE_04
        comb[0] != COMB_NONE && comb[0] != COMB_32X1 && we[0] |-> we[1])
        else $error("paired table not written");

    sum_bit_a: assert property (                                             // RULE_16
        !CARRY_IN[0] |=> SUM_OUT[0] == LUT_OUT[0])
        else $error("sum bit without carry wrong");

    cfg_read_a: assert property (
        REG_RD && REG_ADDR == ADDR_CFG0 |=> REG_RDATA == $past(cfg_ff[0]))
        else $error("configuration read back wrong");

    latch_c: cover property (latch_en[0] && clk_lvl[0] && ce_act[0] ##1 clk_lvl[0]);
    ram32_c: cover property (comb[0] == COMB_32X1 && we[1]);
    async_c: cover property (async_en[1] && opp_act[1] && !clk_edge[1]);
    bus_c:   cover property (!BUS_EN_N[0] && !BUS_EN_N[1] && BUS_DATA[0] != BUS_DATA[1]);
endmodule

// File: sim/lbp_fabric.sv
// model of the other tri-state drivers that share the on-chip bus net
`timescale 1ns/1ps
module lbp_fabric (
    input  wire logic [1:0] other_data,
    input  wire logic [1:0] other_en_n,
    output logic            bus_in
);
    always_comb begin
        bus_in = 1'b1;
        for (int i = 0; i < 2; i++) begin
            if (!other_en_n[i]) begin
                bus_in = bus_in & other_data[i];
            end
        end
    end
endmodule

// File: sim/tb_top.sv
// self-checking testbench of the logic block slice pair
`timescale 1ns/1ps
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %0t output mismatch got %h exp %h", $time, g, e); end end
module tb_top;
    import lbp_pkg::*;
    typedef struct {int due; int sel; logic [15:0] exp;} lbp_note_s;
    // storage steps: {clk, ce, init, opp, bypass[1:0], expected q[1:0]}
    localparam logic [7:0]  STEPS [27] = '{8'h48, 8'hCA, 8'h06, 8'h86, 8'h26, 8'hA5, 8'h11,
        8'h92, 8'h32, 8'hB1, 8'h4D, 8'hCF, 8'h4F, 8'hC5, 8'hCA, 8'h46, 8'h21, 8'h12, 8'h0A,
        8'h85, 8'h45, 8'hC9, 8'h45, 8'hF9, 8'h70, 8'hE4, 8'h66};
    localparam int          SEG_AT [5] = '{0, 13, 16, 18, 23};
    localparam logic [15:0] SEG_CFG [5] = '{16'h0380, 16'h03C0, 16'h0B80, 16'h2380,
        16'hD380};
    logic                       ref_clk = 1'b0;
    logic                       resetn = 1'b0;
    logic [ADDR_W-1:0]          reg_addr = '0;
    logic [DATA_W-1:0]          reg_wdata = '0;
    logic                       reg_wr = 1'b0;
    logic                       reg_rd = 1'b0;
    logic [DATA_W-1:0]          reg_rdata;
    logic [N_CELL*LUT_IN_W-1:0] lut_in = '0;
    logic [N_CELL-1:0]          byp = '0, wd = '0, feed = '0;
    logic [N_SLICE-1:0]         sclk = '0, ce = '0, initf = '0, oppf = '0;
    logic [N_SLICE-1:0]         we = '0, cin = '0, fsel = '0;
    logic                       ssel = 1'b0;
    logic [N_DRV-1:0]           bdata = '0, ben_n = '1;
    logic [1:0]                 odata = '0, oen_n = '1;
    logic                       bus_in, six_out, bus_out;
    logic [N_CELL-1:0]          lut_out, q_out, sum_out, feed_out;
    logic [N_SLICE-1:0]         carry_out, five_out;
    logic [LUT_DEPTH-1:0]       tab [N_CELL];
    lbp_note_s                  notes [$];
    int                         cyc = 0, mismatches = 0, checked = 0;

    lbp_fabric u_fab (.other_data(odata), .other_en_n(oen_n), .bus_in(bus_in));
    lbp_block uut (
        .REF_CLK(ref_clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LUT_IN(lut_in),
        .BYPASS_IN(byp), .SLICE_CLK(sclk), .SLICE_CE(ce), .INIT_FORCE(initf),
        .OPPOSITE_FORCE(oppf), .RAM_WE(we), .RAM_WD(wd), .CARRY_IN(cin), .FIVE_SEL(fsel),
        .SIX_SEL(ssel), .FEED_IN(feed), .BUS_DATA(bdata), .BUS_EN_N(ben_n), .BUS_IN(bus_in),
        .LUT_OUT(lut_out), .Q_OUT(q_out), .SUM_OUT(sum_out), .CARRY_OUT(carry_out),
        .FIVE_OUT(five_out), .SIX_OUT(six_out), .FEED_OUT(feed_out), .BUS_OUT(bus_out));

    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    function automatic logic [15:0] obs(int sel);
        case (sel)
            0: return reg_rdata;
            1: return 16'(lut_out);
            2: return 16'(five_out);
            3: return 16'(six_out);
            4: return 16'(sum_out);
            5: return 16'(carry_out);
            6: return 16'(q_out);
            7: return 16'(feed_out);
            default: return 16'(bus_out);
        endcase
    endfunction

    // scoreboard: each note falls due in the cycle its result stands
    always @(negedge ref_clk) begin
        lbp_note_s n;
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            n = notes.pop_front();
            `CMP(obs(n.sel), n.exp)
        end
    end

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // called right after an edge: result stands from the next edge on
    task automatic note(int sel, logic [15:0] e);
        notes.push_back('{cyc + 2, sel, e});
    endtask

    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        note(0, e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        note(0, 16'h0000);
    endtask

    task automatic step(logic [7:0] s);
        @(posedge ref_clk);
        sclk[0]  <= s[7];
        ce[0]    <= s[6];
        initf[0] <= s[5];
        oppf[0]  <= s[4];
        byp[1:0] <= s[3:2];
        note(6, {14'h0000, s[1:0]});
    endtask

    task automatic ram_edge(int s, logic [3:0] a, logic f, logic [3:0] d);
        @(posedge ref_clk);
        lut_in[8*s +: 4] <= a;
        fsel[s]          <= f;
        wd               <= d;
        @(posedge ref_clk);
        sclk[s] <= 1'b1;
        we[s]   <= 1'b1;
        @(posedge ref_clk);
        sclk[s] <= 1'b0;
        we[s]   <= 1'b0;
    endtask

    initial begin
        repeat (2000) @(posedge ref_clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        logic [15:0] li, rv, cfg, mv;
        logic [3:0]  t, sm, a, b, d;
        logic [1:0]  co, fv;
        logic        cy, di, bx, f;
        void'($urandom(29));
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        wr(ADDR_STAT, 16'hFFFF);
        for (int i = 0; i < 8; i++) begin
            cfg = i < 4 ? LUT_RST : i < 6 ? CFG_RST : 16'(MISC_RST);
            rd(3'(i), i == 7 ? 16'h0001 << STAT_BUS : cfg);
        end
        for (int c = 0; c < N_CELL; c++) begin
            tab[c] = 16'($urandom);
            wr(ADDR_LUT0 + 3'(c), tab[c]);
        end
        mv = 16'($urandom);
        wr(ADDR_MISC, mv);
        rd(ADDR_MISC, {14'h0000, mv[1:0]});
        for (int i = 0; i < 256; i++) begin
            li = 16'($urandom);
            rv = 16'($urandom);
            @(posedge ref_clk);
            lut_in <= li;
            {fsel, ssel, feed, cin, byp} <= 13'(rv);
            {bdata, odata, ben_n, oen_n} <= 8'(i);
            for (int c = 0; c < N_CELL; c++) t[c] = tab[c][li[4*c +: 4]];
            for (int s = 0; s < N_SLICE; s++) begin
                cy = rv[4+s];
                for (int c = 2*s; c < 2*s + 2; c++) begin
                    sm[c] = t[c] ^ cy;
                    di = mv[s] ? rv[c] : (li[4*c] & li[4*c+1]);
                    cy = t[c] ? cy : di;
                end
                co[s] = cy;
                fv[s] = rv[11+s] ? t[2*s+1] : t[2*s];
            end
            bx = 1'b1;
            for (int k = 0; k < 4; k++) if (!i[k]) bx &= i[4+k];
            note(1, 16'(t));
            note(2, 16'(fv));
            note(3, 16'(rv[10] ? fv[1] : fv[0]));
            note(4, 16'(sm));
            note(5, 16'(co));
            note(7, 16'(rv[9:6]));
            note(8, 16'(bx));
        end
        for (int i = 0; i < 27; i++) begin
            for (int k = 0; k < 5; k++) if (i == SEG_AT[k]) wr(ADDR_CFG0, SEG_CFG[k]);
            step(STEPS[i]);
        end
        // distributed RAM of slice 0 in every combine mode
        for (int m = 0; m < 4; m++) begin
            cfg = m == 0 ? 16'(LUT_RAM) << CFG_MODE_LSB : 16'(m) << CFG_COMB_LSB;
            wr(ADDR_CFG0, cfg);
            a = 4'($urandom);
            f = 1'($urandom);
            d = 4'($urandom);
            ram_edge(0, a, f, d);
            if (m != 2 || !f) tab[0][a] = d[0];
            if (m == 1) tab[1][a] = d[1];
            if (m == 3 || (m == 2 && f)) tab[1][a] = d[0];
            rd(ADDR_LUT0, tab[0]);
            rd(ADDR_LUT0 + 3'(1), tab[1]);
            // read port: 16x2 and 32x1 modes read the second table at the first table's address
            b = 4'($urandom);
            @(posedge ref_clk);
            lut_in[7:0] <= {b, a};
            li = {lut_in[15:8], b, a};
            for (int c = 0; c < N_CELL; c++) t[c] = tab[c][li[4*c +: 4]];
            if (m == 1 || m == 2) t[1] = tab[1][a];
            note(1, 16'(t));
            note(2, 16'({fsel[1] ? t[3] : t[2], f ? t[1] : t[0]}));
        end
        // slice 1: cell 2 as RAM, cell 3 as shift register
        wr(ADDR_CFG1, 16'h0009);
        a = 4'($urandom);
        d = 4'($urandom);
        ram_edge(1, a, 1'b0, d);
        tab[2][a] = d[2];
        tab[3] = {tab[3][14:0], d[3]};
        rd(ADDR_LUT0 + 3'(2), tab[2]);
        rd(ADDR_LUT0 + 3'(3), tab[3]);
        cfg = 16'($urandom);
        wr(ADDR_CFG1, cfg);
        rd(ADDR_CFG1, cfg);
        for (int i = 0; i < 10 && notes.size() > 0; i++) @(posedge ref_clk);
        if (notes.size() > 0) mismatches++;
        report_and_stop();
    end
endmodule
